// ==== verilog/isr_pkg.sv ====
// constants, register map and states of the start reservation controller
// assumes an axi4-lite master on aclk and a bus driven through open-drain pins
// Functional notes
// RULE1: reservation held, start issued after stop
// RULE2: free bus starts now, busy reserves
// RULE3: lost arbitration unless addressed as slave, or release, means not joined
// RULE4: software waits widths plus four before status
// RULE5: shift data ignored until stop while reserved
// RULE6: stop interrupt, address write starts master
// RULE7: request after start detect is reservation
// RULE8: prohibited reservation rejects request when not joined
// RULE9: start fail flag set five clocks later
// RULE10: power-up option clear means bus busy
// RULE11: software frees bus by stop request sequence
// RULE12: power-up option set means bus free
// RULE13: start detected even joining mid traffic
// RULE14: software releases within 4 to 72 clocks
// RULE15: software never clears start or stop early
// RULE16: no stop interrupt means polling status
// RULE17: release bit leaves transfer to standby
// RULE18: start request self clears, held while reserved
package isr_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_FLAG = 8'h0c;
   localparam logic [7:0] ADDR_SHIFT = 8'h10;
   localparam logic [7:0] ADDR_LOW_WIDTH = 8'h14;
   localparam logic [7:0] ADDR_HIGH_WIDTH = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   // ****************************************
   // field positions
   // ****************************************
   localparam int C0_STOP_REQ = 0;
   localparam int C0_START_REQ = 1;
   localparam int C0_STOP_IRQ_EN = 4;
   localparam int C0_LEAVE = 6;
   localparam int C0_ENABLE = 7;
   localparam int C1_START_AT_EN = 0;
   localparam int ST_STOP_DET = 0;
   localparam int ST_START_DET = 1;
   localparam int ST_ARB_LOST = 2;
   localparam int ST_SLAVE = 3;
   localparam int ST_EXT_CODE = 5;
   localparam int ST_MASTER = 7;
   localparam int FL_RSV_DIS = 0;
   localparam int FL_BUSY = 6;
   localparam int FL_START_FAIL = 7;
   localparam int EV_STOP = 0;
   localparam int EV_START = 1;
   localparam int EV_FAIL = 2;
   localparam int EV_MASTER = 3;
   localparam int EV_W = 4;
   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [7:0] WIDTH_RST = 8'h10;
   localparam int FAIL_DELAY_CLK = 5;
   localparam int WAIT_EXTRA_CLK = 4;
   typedef enum logic [2:0] {S_IDLE, S_RESERVED, S_START_HOLD, S_START_LOW, S_MASTER, S_STOP} isr_state_t;
endpackage

// ==== verilog/isr_ctrl.sv ====
// start reservation and bus join logic with axi4-lite registers
// assumes open-drain pins resolved outside; line inputs asynchronous to aclk
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe,
   input wire logic serial_clock_line_i,
   output logic serial_clock_line_o,
   output logic serial_clock_line_oe,
   input wire logic arb_lost,
   input wire logic slave_addressed,
   input wire logic ext_code_rx,
   output logic bus_event_irq
);
   // ****************************************
   // line synchronisers and conditions
   // ****************************************
   logic [1:0] sda_sync_q, sda_sync_d, scl_sync_q, scl_sync_d;
   logic sda_prev_q, sda_prev_d, scl_prev_q, scl_prev_d;
   logic start_cond, stop_cond;
   always_comb begin
      sda_sync_d = {sda_sync_q[0], serial_data_line_i};
      scl_sync_d = {scl_sync_q[0], serial_clock_line_i};
      sda_prev_d = sda_sync_q[1];
      scl_prev_d = scl_sync_q[1];
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_sync_q <= 2'h3;
         scl_sync_q <= 2'h3;
         sda_prev_q <= 1'b1;
         scl_prev_q <= 1'b1;
      end else begin
         sda_sync_q <= sda_sync_d;
         scl_sync_q <= scl_sync_d;
         sda_prev_q <= sda_prev_d;
         scl_prev_q <= scl_prev_d;
      end
   end
   // RULE13: start recognised mid traffic
   assign start_cond = sda_prev_q && !sda_sync_q[1] && scl_sync_q[1] && scl_prev_q;
   assign stop_cond = !sda_prev_q && sda_sync_q[1] && scl_sync_q[1] && scl_prev_q;

   // ****************************************
   // registers and control state
   // ****************************************
   logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, rsv_q, rsv_d;
   logic [7:0] shift_reg_q, shift_reg_d, low_w_q, low_w_d, high_w_q, high_w_d;
   logic [isr_pkg::EV_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, ev;
   logic busy_q, busy_d, fail_q, fail_d, master_q, master_d, joined_q, joined_d;
   logic start_det_q, start_det_d, stop_det_q, stop_det_d, arb_q, arb_d;
   logic shift_valid_q, shift_valid_d;
   logic [2:0] fail_cnt_q, fail_cnt_d;
   logic [7:0] tcnt_q, tcnt_d;
   isr_pkg::isr_state_t st_q, st_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic do_wr, do_rd, enable, rsv_dis;
   logic [7:0] status_v, flag_v;

   assign enable = ctrl0_q[isr_pkg::C0_ENABLE];
   assign rsv_dis = rsv_q[isr_pkg::FL_RSV_DIS];
   assign status_v = {master_q, 1'b0, ext_code_rx, 1'b0, slave_addressed, arb_q, start_det_q, stop_det_q};
   assign flag_v = {fail_q, busy_q, 5'h00, rsv_dis};

   // ****************************************
   // axi4-lite slave
   // ****************************************
   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready = !w_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = 2'h0;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rresp = 2'h0;
   assign s_axi_rdata = rd_q;
   assign do_wr = aw_q && w_q && !bv_q;
   assign do_rd = s_axi_arvalid && !rv_q;
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      rv_d = rv_q;
      rd_d = rd_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (do_wr) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      if (do_rd) begin
         rv_d = 1'b1;
         case (s_axi_araddr)
            isr_pkg::ADDR_CTRL0: rd_d = {24'h000000, ctrl0_q};
            isr_pkg::ADDR_CTRL1: rd_d = {24'h000000, ctrl1_q};
            isr_pkg::ADDR_STATUS: rd_d = {24'h000000, status_v};
            isr_pkg::ADDR_FLAG: rd_d = {24'h000000, flag_v};
            isr_pkg::ADDR_SHIFT: rd_d = {24'h000000, shift_reg_q};
            isr_pkg::ADDR_LOW_WIDTH: rd_d = {24'h000000, low_w_q};
            isr_pkg::ADDR_HIGH_WIDTH: rd_d = {24'h000000, high_w_q};
            isr_pkg::ADDR_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
            isr_pkg::ADDR_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
            default: rd_d = 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // reservation engine
   // ****************************************
   always_comb begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      rsv_d = rsv_q;
      shift_reg_d = shift_reg_q;
      shift_valid_d = shift_valid_q;
      low_w_d = low_w_q;
      high_w_d = high_w_q;
      irq_mask_d = irq_mask_q;
      busy_d = busy_q;
      fail_d = fail_q;
      master_d = master_q;
      joined_d = joined_q;
      start_det_d = start_det_q;
      stop_det_d = stop_det_q;
      arb_d = arb_q;
      fail_cnt_d = fail_cnt_q;
      tcnt_d = tcnt_q;
      st_d = st_q;
      ev = '0;
      if (do_wr) begin
         case (awa_q)
            isr_pkg::ADDR_CTRL0: begin
               ctrl0_d = wd_q[7:0];
               if (wd_q[isr_pkg::C0_ENABLE] && !ctrl0_q[isr_pkg::C0_ENABLE]) begin
                  // RULE10: busy after enable
                  // RULE12: option set means free
                  busy_d = !ctrl1_q[isr_pkg::C1_START_AT_EN];
                  joined_d = 1'b0;
               end
            end
            isr_pkg::ADDR_CTRL1: ctrl1_d = wd_q[7:0];
            isr_pkg::ADDR_FLAG: rsv_d = {7'h00, wd_q[isr_pkg::FL_RSV_DIS]};
            isr_pkg::ADDR_SHIFT: begin
               shift_reg_d = wd_q[7:0];
               shift_valid_d = 1'b1;
            end
            isr_pkg::ADDR_LOW_WIDTH: low_w_d = wd_q[7:0];
            isr_pkg::ADDR_HIGH_WIDTH: high_w_d = wd_q[7:0];
            isr_pkg::ADDR_IRQ_MASK: irq_mask_d = wd_q[isr_pkg::EV_W-1:0];
            default: ;
         endcase
      end
      // RULE3: arbitration lost leaves the bus unless addressed as slave
      if (arb_lost) begin
         arb_d = 1'b1;
         master_d = 1'b0;
         joined_d = slave_addressed;
      end
      if (start_cond) begin
         start_det_d = 1'b1;
         stop_det_d = 1'b0;
         busy_d = 1'b1;
         ev[isr_pkg::EV_START] = 1'b1;
      end
      if (stop_cond) begin
         stop_det_d = 1'b1;
         start_det_d = 1'b0;
         busy_d = 1'b0;
         joined_d = 1'b0;
         arb_d = arb_lost;
         // RULE6: stop interrupt when enabled
         // RULE16: otherwise poll status
         ev[isr_pkg::EV_STOP] = ctrl0_q[isr_pkg::C0_STOP_IRQ_EN];
      end
      // RULE17: release goes to standby
      if (ctrl0_q[isr_pkg::C0_LEAVE]) begin
         ctrl0_d[isr_pkg::C0_LEAVE] = 1'b0;
         joined_d = 1'b0;
         master_d = 1'b0;
         st_d = (st_q == isr_pkg::S_RESERVED) ? isr_pkg::S_RESERVED : isr_pkg::S_IDLE;
      end
      // RULE9: fail flag after five clocks
      if (fail_cnt_q != 3'h0) begin
         fail_cnt_d = fail_cnt_q - 3'h1;
         if (fail_cnt_q == 3'h1) begin
            fail_d = 1'b1;
            ev[isr_pkg::EV_FAIL] = 1'b1;
         end
      end
      if (tcnt_q != 8'h00) begin
         tcnt_d = tcnt_q - 8'h01;
      end
      if (!enable) begin
         st_d = isr_pkg::S_IDLE;
         ctrl0_d[isr_pkg::C0_START_REQ] = 1'b0;
         ctrl0_d[isr_pkg::C0_STOP_REQ] = 1'b0;
         master_d = 1'b0;
      end else begin
         unique case (st_q)
            isr_pkg::S_IDLE: begin
               if (ctrl0_q[isr_pkg::C0_START_REQ]) begin
                  fail_d = (fail_cnt_q == 3'h1);
                  if (!busy_q) begin
                     // RULE2: free bus starts now
                     st_d = isr_pkg::S_START_HOLD;
                     tcnt_d = high_w_q;
                  end else if (!rsv_dis && !joined_q) begin
                     // RULE7: busy bus reserves
                     st_d = isr_pkg::S_RESERVED;
                  end else begin
                     // RULE8: prohibited request rejected
                     // RULE18: clear request on reject
                     ctrl0_d[isr_pkg::C0_START_REQ] = 1'b0;
                     fail_cnt_d = 3'(isr_pkg::FAIL_DELAY_CLK - 1);
                  end
               end else if (ctrl0_q[isr_pkg::C0_STOP_REQ]) begin
                  st_d = isr_pkg::S_STOP;
                  tcnt_d = low_w_q;
               end
            end
            isr_pkg::S_RESERVED: begin
               // RULE5: shift data held until stop
               // RULE1: start issued after stop
               if (stop_cond) begin
                  st_d = isr_pkg::S_START_HOLD;
                  tcnt_d = high_w_q;
               end
            end
            isr_pkg::S_START_HOLD: begin
               if (tcnt_q == 8'h00) begin
                  st_d = isr_pkg::S_START_LOW;
                  tcnt_d = low_w_q;
               end
            end
            isr_pkg::S_START_LOW: begin
               if (tcnt_q == 8'h00) begin
                  // RULE18: clear request after start
                  ctrl0_d[isr_pkg::C0_START_REQ] = 1'b0;
                  master_d = 1'b1;
                  joined_d = 1'b1;
                  busy_d = 1'b1;
                  ev[isr_pkg::EV_MASTER] = 1'b1;
                  st_d = isr_pkg::S_MASTER;
               end
            end
            isr_pkg::S_MASTER: begin
               if (shift_valid_q) begin
                  shift_valid_d = 1'b0;
               end
               if (ctrl0_q[isr_pkg::C0_STOP_REQ]) begin
                  st_d = isr_pkg::S_STOP;
                  tcnt_d = low_w_q;
               end else if (!master_q) begin
                  st_d = isr_pkg::S_IDLE;
               end
            end
            isr_pkg::S_STOP: begin
               if (tcnt_q == 8'h00) begin
                  ctrl0_d[isr_pkg::C0_STOP_REQ] = 1'b0;
                  master_d = 1'b0;
                  st_d = isr_pkg::S_IDLE;
               end
            end
         endcase
      end
      // read of irq status clears; set wins
      irq_stat_d = ((do_rd && s_axi_araddr == isr_pkg::ADDR_IRQ_STAT) ? '0 : irq_stat_q) | ev;
   end
   assign bus_event_irq = |(irq_stat_q & irq_mask_q);

   // ****************************************
   // pin drive
   // ****************************************
   assign serial_data_line_o = 1'b0;
   assign serial_clock_line_o = 1'b0;
   assign serial_data_line_oe = (st_q == isr_pkg::S_START_LOW) || (st_q == isr_pkg::S_STOP);
   assign serial_clock_line_oe = 1'b0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0_q <= isr_pkg::CTRL0_RST;
         ctrl1_q <= isr_pkg::CTRL1_RST;
         rsv_q <= isr_pkg::FLAG_RST;
         shift_reg_q <= 8'h00;
         shift_valid_q <= 1'b0;
         low_w_q <= isr_pkg::WIDTH_RST;
         high_w_q <= isr_pkg::WIDTH_RST;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         busy_q <= 1'b1;
         fail_q <= 1'b0;
         master_q <= 1'b0;
         joined_q <= 1'b0;
         start_det_q <= 1'b0;
         stop_det_q <= 1'b0;
         arb_q <= 1'b0;
         fail_cnt_q <= 3'h0;
         tcnt_q <= 8'h00;
         st_q <= isr_pkg::S_IDLE;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         rv_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h00000000;
         rd_q <= 32'h00000000;
      end else begin
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         rsv_q <= rsv_d;
         shift_reg_q <= shift_reg_d;
         shift_valid_q <= shift_valid_d;
         low_w_q <= low_w_d;
         high_w_q <= high_w_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         busy_q <= busy_d;
         fail_q <= fail_d;
         master_q <= master_d;
         joined_q <= joined_d;
         start_det_q <= start_det_d;
         stop_det_q <= stop_det_d;
         arb_q <= arb_d;
         fail_cnt_q <= fail_cnt_d;
         tcnt_q <= tcnt_d;
         st_q <= st_d;
         aw_q <= aw_d;
         w_q <= w_d;
         bv_q <= bv_d;
         rv_q <= rv_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
      end
   end
endmodule
`default_nettype wire

// ==== test/isr_ctrl_properties.sv ====
// port assertions of the start reservation controller
// assumes bind onto isr_ctrl with widths left at reset
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_data_line_o,
   input wire logic serial_data_line_oe,
   input wire logic serial_clock_line_i,
   input wire logic serial_clock_line_o,
   input wire logic serial_clock_line_oe,
   input wire logic bus_event_irq
);
   // ****************
   // properties
   // ****************
   logic [1:0] rel_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (!aresetn) rel_q <= 2'h0;
      else if (rel_q != 2'h3) rel_q <= rel_q + 2'h1;
   end
   property p_wr_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_rd_resp; s_axi_arvalid && s_axi_arready && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_okay; s_axi_bvalid || s_axi_rvalid |-> (s_axi_bresp | s_axi_rresp) == 2'h0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_open_drain; !serial_data_line_o && !serial_clock_line_o && !serial_clock_line_oe; endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   property p_start_scl; $rose(serial_data_line_oe) |-> serial_clock_line_i; endproperty
   a_start_scl: assert property (p_start_scl) else $error("start with clock low");
   property p_start_len; $rose(serial_data_line_oe) |=> serial_data_line_oe [*8]; endproperty
   a_start_len: assert property (p_start_len) else $error("start too short");
   property p_quiet; rel_q < 2'h2 |-> !serial_data_line_oe; endproperty
   a_quiet: assert property (p_quiet) else $error("start right after reset");
   c_start: cover property ($rose(serial_data_line_oe));
   c_irq: cover property ($rose(bus_event_irq));
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind isr_ctrl isr_ctrl_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_data_line_o, .serial_data_line_oe, .serial_clock_line_i,
   .serial_clock_line_o, .serial_clock_line_oe, .bus_event_irq);
`default_nettype wire

// ==== test/isr_bus_model.sv ====
// other masters on the shared two-wire bus
// assumes pull-ups on both lines, 800 ns clock within frames
`timescale 1ns/1ps
`default_nettype none
module isr_bus_model (
   input wire logic sda_oe,
   input wire logic scl_oe,
   output logic sda,
   output logic scl
);
   // ****************
   // wired lines
   // ****************
   logic sda_drv = 1'h1;
   logic scl_drv = 1'h1;
   assign sda = sda_drv & !sda_oe;
   assign scl = scl_drv & !scl_oe;
   task automatic frame_start();
      #37 sda_drv = 1'h0;
      repeat (3) begin
         #400 scl_drv = 1'h0;
         #400 scl_drv = 1'h1;
      end
   endtask
   task automatic frame_stop();
      #437 scl_drv = 1'h0;
      #400 sda_drv = 1'h0;
      #400 scl_drv = 1'h1;
      #400 sda_drv = 1'h1;
      #400;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_i2c_start_reservation_ctrl.sv ====
// self-checking bench of the start reservation controller
// assumes the bound checker and the bus model beside it
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_start_reservation_ctrl;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic arb_lost = 1'h0;
   logic slave_addressed = 1'h0;
   logic ext_code_rx = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_event_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, rd_q;
   logic sda, scl, serial_data_line_o, serial_data_line_oe, serial_clock_line_o, serial_clock_line_oe;
   int mismatches = 0;
   int tests_run = 0;
   int oe_seen = 0;
   isr_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_data_line_i(sda),
      .serial_data_line_o, .serial_data_line_oe, .serial_clock_line_i(scl), .serial_clock_line_o,
      .serial_clock_line_oe, .arb_lost, .slave_addressed, .ext_code_rx, .bus_event_irq);
   isr_bus_model u_bus (.sda_oe(serial_data_line_oe), .scl_oe(serial_clock_line_oe), .sda, .scl);
   // ****************
   // shared tasks
   // ****************
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      if (serial_data_line_oe === 1'h1) oe_seen++;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 100);
      s_axi_bready <= 1'h0;
      chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 100);
      s_axi_rready <= 1'h0;
      rd_q = s_axi_rdata;
      chk(what, e, rd_q & m);
   endtask
   task automatic wait_hi(input string what, input int irq, input int lim);
      int n;
      n = 0;
      while ((irq ? bus_event_irq : serial_data_line_oe) !== 1'h1 && n < lim) begin
         @(posedge aclk);
         n++;
      end
      chk(what, 32'h1, {31'h0, irq ? bus_event_irq : serial_data_line_oe});
   endtask
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      oe_seen = 0;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_busy_reserve();
      do_reset();
      rchk("width", 8'h14, 32'hff, {24'h0, isr_pkg::WIDTH_RST});
      rchk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
      wr(8'h00, 32'h88);
      rchk("busy", 8'h0c, 32'h40, 32'h40);
      wr(8'h00, 32'h8a);
      repeat (50) @(posedge aclk);
      chk("early start", 32'h0, 32'(oe_seen));
      rchk("held request", 8'h00, 32'h02, 32'h02);
      u_bus.frame_stop();
      wait_hi("start after stop", 0, 100);
      repeat (40) @(posedge aclk);
      rchk("master", 8'h08, 32'h80, 32'h80);
      rchk("request done", 8'h00, 32'h02, 32'h00);
      $display("test busy_reserve done");
   endtask
   task automatic t_stop_free();
      do_reset();
      wr(8'h14, 32'h20);
      rchk("low width", 8'h14, 32'hff, 32'h20);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h80);
      rchk("busy at enable", 8'h0c, 32'h40, 32'h40);
      wr(8'h00, 32'h81);
      wait_hi("stop drive", 0, 40);
      repeat (50) @(posedge aclk);
      rchk("bus freed", 8'h0c, 32'h40, 32'h00);
      rchk("stop request done", 8'h00, 32'h01, 32'h00);
      $display("test stop_free done");
   endtask
   task automatic t_reserve();
      do_reset();
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h98);
      wr(8'h20, 32'h1);
      u_bus.frame_start();
      rchk("start seen", 8'h08, 32'h02, 32'h02);
      wr(8'h00, 32'h9a);
      wr(8'h10, 32'ha5);
      repeat (40) @(posedge aclk);
      chk("start in frame", 32'h0, 32'(oe_seen));
      u_bus.frame_stop();
      wait_hi("stop irq", 1, 50);
      wait_hi("reserved start", 0, 100);
      rchk("stop event", 8'h1c, 32'h01, 32'h01);
      @(posedge aclk);
      chk("irq cleared", 32'h0, {31'h0, bus_event_irq});
      $display("test reserve done");
   endtask
   task automatic t_reject();
      do_reset();
      wr(8'h0c, 32'h1);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h88);
      u_bus.frame_start();
      @(posedge aclk);
      arb_lost <= 1'h1;
      ext_code_rx <= 1'h1;
      @(posedge aclk);
      arb_lost <= 1'h0;
      wr(8'h00, 32'hc8);
      ext_code_rx <= 1'h0;
      wr(8'h00, 32'h8a);
      repeat (isr_pkg::FAIL_DELAY_CLK) @(posedge aclk);
      rchk("start fail", 8'h0c, 32'h80, 32'h80);
      rchk("request dropped", 8'h00, 32'h02, 32'h00);
      u_bus.frame_stop();
      repeat (60) @(posedge aclk);
      chk("rejected start", 32'h0, 32'(oe_seen));
      $display("test reject done");
   endtask
   task automatic t_free_start();
      do_reset();
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h88);
      rchk("free", 8'h0c, 32'h40, 32'h00);
      wr(8'h20, 32'h8);
      wr(8'h00, 32'h8a);
      wait_hi("free start", 0, 40);
      repeat (32 + isr_pkg::WAIT_EXTRA_CLK) @(posedge aclk);
      rchk("master", 8'h08, 32'h80, 32'h80);
      chk("irq", 32'h1, {31'h0, bus_event_irq});
      wr(8'h20, 32'h1);
      @(posedge aclk);
      chk("masked", 32'h0, {31'h0, bus_event_irq});
      rchk("master event", 8'h1c, 32'h08, 32'h08);
      wr(8'h20, 32'h8);
      @(posedge aclk);
      chk("read clear", 32'h0, {31'h0, bus_event_irq});
      $display("test free_start done");
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      $display("[ERR] watchdog expected done seen hang");
      print_verdict();
   end
   initial begin
      t_busy_reserve();
      t_stop_free();
      t_reserve();
      t_reject();
      t_free_start();
      print_verdict();
   end
endmodule
`default_nettype wire
